// ---- logic/unique_node_id_rom_map_regs.sv ----
// What this block does
// - unique id is upper and lower quadlets
// - hardware reset clears upper id to zero
// - eeprom loads id after reset, then frozen
// - without eeprom firmware loads once, then frozen
// - only global reset returns id bits
// - lower id clears and locks like upper
// - both id registers read-only, default zero
// - rom read address is base plus offset
// - map base bits 31..10, low bits zero
// - failed posted write records error info
// - low capture holds offset bits 31..0
// - high capture holds requester id, offset top
//
// register bank for the node unique id, rom mapping and write capture
// assumes all inputs are synchronous to clk_in and reset_in is global
`timescale 1ns/1ps
`default_nettype none
module unique_node_id_rom_map_regs
   import unique_node_id_rom_pkg::*;
#(
   parameter int ADDR_W = 8 // register port address width
)
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic soft_reset_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [31:0] wr_data_in,
   input wire logic wr_strobe_in,
   input wire logic rd_strobe_in,
   output logic [31:0] rd_data_out,
   input wire logic eeprom_present_in,
   input wire logic eeprom_load_valid_in,
   input wire logic eeprom_load_lower_in,
   input wire logic [31:0] eeprom_load_data_in,
   input wire logic rom_read_valid_in,
   input wire logic [47:0] rom_read_offset_in,
   output logic rom_host_addr_valid_out,
   output logic [31:0] rom_host_addr_out,
   input wire logic write_fail_in,
   input wire logic [47:0] write_fail_offset_in,
   input wire logic [15:0] write_fail_source_in,
   output logic [63:0] unique_id_out,
   output logic irq_out
);
   // the offsets need eight address bits
   if (ADDR_W < 8)
   begin : g_bad_width
      $error("ADDR_W must be at least 8");
   end

   // load paths into the two id words
   id_load_if upper_if ();
   id_load_if lower_if ();

   // software registers and captured state
   logic [31:0] map_base_reg; // rom mapping base
   logic [31:0] fail_low_reg; // failed write offset low
   logic [31:0] fail_high_reg; // requester and offset high
   logic [IRQ_W-1:0] irq_status_reg; // sticky events
   logic [IRQ_W-1:0] irq_status_next;
   logic [IRQ_W-1:0] irq_mask_reg; // one enables a source
   logic [31:0] rd_data_reg; // read answer, one cycle late
   logic [31:0] rd_mux; // selected read word
   logic rom_valid_reg; // rom mapping answer strobe
   logic [31:0] rom_addr_reg; // rom mapping host address
   logic [63:0] id_out_reg; // id copy for the output port
   logic both_locked_reg; // delayed lock state for edge
   logic irq_reg; // interrupt line

   // address decode, kept apart from the storage
   wire logic [7:0] ofs = addr_in[7:0];
   wire logic upper_addr = ofs[7:0] == OFS_ID_UPPER;
   wire logic hi_zero = (ADDR_W == 8) ? 1'b1 :
      ~|(addr_in >> 8);
   wire logic hit_map = hi_zero && (ofs == OFS_MAP);
   wire logic hit_mask = hi_zero && (ofs == OFS_IRQ_MASK);
   wire logic hit_status = hi_zero && (ofs == OFS_IRQ_STATUS);
   wire logic hit_fw_upper = hi_zero && (ofs == OFS_FW_UPPER);
   wire logic hit_fw_lower = hi_zero && (ofs == OFS_FW_LOWER);

   // write strobes per target
   wire logic wr_map = wr_strobe_in && hit_map;
   wire logic wr_mask = wr_strobe_in && hit_mask;
   wire logic wr_status = wr_strobe_in && hit_status;
   wire logic wr_fw_upper = wr_strobe_in && hit_fw_upper;
   wire logic wr_fw_lower = wr_strobe_in && hit_fw_lower;

   // eeprom loads only count when the eeprom is really there
   wire logic ee_upper = eeprom_present_in && eeprom_load_valid_in &&
      !eeprom_load_lower_in;
   wire logic ee_lower = eeprom_present_in && eeprom_load_valid_in &&
      eeprom_load_lower_in;

   // firmware loads are honoured only with no eeprom fitted
   wire logic fw_upper = wr_fw_upper && !eeprom_present_in;
   wire logic fw_lower = wr_fw_lower && !eeprom_present_in;

   // a load that is turned away raises the refuse event
   wire logic refused = ((wr_fw_upper || wr_fw_lower) &&
      eeprom_present_in) ||
      ((fw_upper || ee_upper) && upper_if.locked) ||
      ((fw_lower || ee_lower) && lower_if.locked);

   // lock event fires once, when the second word locks
   wire logic both_locked = upper_if.locked && lower_if.locked;
   wire logic lock_event = both_locked && !both_locked_reg;

   // rom mapping: low ten offset bits added to the base
   wire logic rom_hit = rom_read_valid_in &&
      in_rom_window(rom_read_offset_in);
   wire logic [31:0] rom_sum = map_base_reg +
      {22'h0, rom_read_offset_in[9:0]};

   // eeprom wins if both paths try in one cycle; the slots lock anyway
   assign upper_if.load_valid = ee_upper || fw_upper;
   assign upper_if.load_data = ee_upper ? eeprom_load_data_in :
      wr_data_in;
   assign lower_if.load_valid = ee_lower || fw_lower;
   assign lower_if.load_data = ee_lower ? eeprom_load_data_in :
      wr_data_in;

   // the two id words, each holding its own lock
   unique_id_slot upper_slot (
      .clk_in (clk_in),
      .reset_in (reset_in),
      .load_port (upper_if)
   );
   unique_id_slot lower_slot (
      .clk_in (clk_in),
      .reset_in (reset_in),
      .load_port (lower_if)
   );

   // read selection; unmapped words and reserved bits read zero
   always_comb
   begin
      rd_mux = 32'h0000_0000;
      if (!hi_zero)
         rd_mux = 32'h0000_0000; // outside the bank
      else if (upper_addr)
         rd_mux = upper_if.value;
      else if (ofs == OFS_ID_LOWER)
         rd_mux = lower_if.value;
      else if (ofs == OFS_MAP)
         rd_mux = map_base_reg & MAP_KEEP;
      else if (ofs == OFS_FAIL_LOW)
         rd_mux = fail_low_reg;
      else if (ofs == OFS_FAIL_HIGH)
         rd_mux = fail_high_reg;
      else if (ofs == OFS_IRQ_STATUS)
         rd_mux = {29'h0, irq_status_reg};
      else if (ofs == OFS_IRQ_MASK)
         rd_mux = {29'h0, irq_mask_reg};
      else if (ofs == OFS_LOCK_STATUS)
         rd_mux = {30'h0, lower_if.locked, upper_if.locked};
   end

   // sticky status: a new event beats a write-one clear
   always_comb
   begin
      irq_status_next = irq_status_reg;
      if (wr_status)
         irq_status_next = irq_status_reg & ~wr_data_in[IRQ_W-1:0];
      if (write_fail_in)
         irq_status_next[IRQ_FAIL_BIT] = 1'b1;
      if (lock_event)
         irq_status_next[IRQ_LOCK_BIT] = 1'b1;
      if (refused)
         irq_status_next[IRQ_REFUSE_BIT] = 1'b1;
   end

   // read data register; stands only in the cycle after the strobe
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         rd_data_reg <= 32'h0000_0000;
      else if (rd_strobe_in)
         rd_data_reg <= rd_mux;
      else
         rd_data_reg <= 32'h0000_0000;
   end

   // mapping base; the low ten bits are never stored
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
         map_base_reg <= MAP_RESET;
      else if (wr_map)
         map_base_reg <= wr_data_in & MAP_KEEP;
   end

   // failed posted write capture; the latest failure overwrites
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         fail_low_reg <= FAIL_RESET;
         fail_high_reg <= FAIL_RESET;
      end
      else if (write_fail_in)
      begin
         fail_low_reg <= write_fail_offset_in[31:0];
         fail_high_reg <= {write_fail_source_in,
            write_fail_offset_in[47:32]};
      end
   end

   // interrupt state; soft reset clears events but never the id
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
         irq_reg <= 1'b0;
      end
      else if (soft_reset_in)
      begin
         irq_status_reg <= IRQ_RESET;
         irq_mask_reg <= IRQ_RESET;
         irq_reg <= 1'b0;
      end
      else
      begin
         irq_status_reg <= irq_status_next;
         if (wr_mask)
            irq_mask_reg <= wr_data_in[IRQ_W-1:0];
         irq_reg <= |(irq_status_next &
            (wr_mask ? wr_data_in[IRQ_W-1:0] : irq_mask_reg));
      end
   end

   // rom mapping answer, one cycle after the request
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         rom_valid_reg <= 1'b0;
         rom_addr_reg <= 32'h0000_0000;
      end
      else
      begin
         rom_valid_reg <= rom_hit;
         if (rom_hit)
            rom_addr_reg <= rom_sum;
      end
   end

   // id output copy and the lock edge tracker
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         id_out_reg <= {ID_RESET, ID_RESET};
         both_locked_reg <= 1'b0;
      end
      else
      begin
         id_out_reg <= {upper_if.value, lower_if.value};
         both_locked_reg <= both_locked;
      end
   end

   assign rd_data_out = rd_data_reg;
   assign rom_host_addr_valid_out = rom_valid_reg;
   assign rom_host_addr_out = rom_addr_reg;
   assign unique_id_out = id_out_reg;
   assign irq_out = irq_reg;

   // checks on the documented behaviour
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   // an eeprom load into an open upper word
   sequence s_ee_upper_open;
      ee_upper && !upper_if.locked;
   endsequence
   sequence s_upper_took;
      upper_if.locked && upper_if.value == $past(eeprom_load_data_in);
   endsequence

   property p_ee_load;
      s_ee_upper_open |=> s_upper_took;
   endproperty
   a_ee_load: assert property (p_ee_load)
      else $error("eeprom load did not land");

   property p_fw_blocked;
      (wr_fw_upper && eeprom_present_in) ##0 !ee_upper
         |=> $stable(upper_if.value);
   endproperty
   a_fw_blocked: assert property (p_fw_blocked)
      else $error("firmware load taken with eeprom");

   property p_soft_keeps_id;
      soft_reset_in && !upper_if.load_valid && !lower_if.load_valid
         |=> $stable(upper_if.value) && $stable(lower_if.value);
   endproperty
   a_soft_keeps_id: assert property (p_soft_keeps_id)
      else $error("soft reset moved the id");

   property p_id_read;
      rd_strobe_in && hi_zero && upper_addr
         |=> rd_data_out == $past(upper_if.value) ##1
             rd_data_out == 32'h0000_0000 || $past(rd_strobe_in);
   endproperty
   a_id_read: assert property (p_id_read)
      else $error("upper id read wrong");

   property p_id_out;
      1'b1 |=> unique_id_out[31:0] == $past(lower_if.value);
   endproperty
   a_id_out: assert property (p_id_out)
      else $error("unique id output mismatch");

   property p_rom_map;
      rom_hit |=> rom_host_addr_valid_out &&
         rom_host_addr_out == $past(map_base_reg) +
         {22'h0, $past(rom_read_offset_in[9:0])};
   endproperty
   a_rom_map: assert property (p_rom_map)
      else $error("rom host address wrong");

   property p_rom_miss;
      rom_read_valid_in && !in_rom_window(rom_read_offset_in)
         |=> !rom_host_addr_valid_out;
   endproperty
   a_rom_miss: assert property (p_rom_miss)
      else $error("rom answer outside window");

   property p_map_low_zero;
      rd_strobe_in && hit_map |=> rd_data_out[9:0] == 10'h000;
   endproperty
   a_map_low_zero: assert property (p_map_low_zero)
      else $error("map low bits not zero");

   // a soft reset in the same cycle wipes the status bit, so leave it out
   property p_fail_capture;
      write_fail_in && !soft_reset_in
         |=> fail_low_reg == $past(write_fail_offset_in[31:0])
         && fail_high_reg[31:SRC_LSB] == $past(write_fail_source_in)
         && irq_status_reg[IRQ_FAIL_BIT];
   endproperty
   a_fail_capture: assert property (p_fail_capture)
      else $error("failed write not captured");

   property p_irq_line;
      |(irq_status_reg & irq_mask_reg) && !soft_reset_in
         && !wr_status && !wr_mask |=> irq_out;
   endproperty
   a_irq_line: assert property (p_irq_line)
      else $error("interrupt not raised");
endmodule : unique_node_id_rom_map_regs
`default_nettype wire

// ---- logic/unique_node_id_rom_pkg.sv ----
// constants for the unique-id, rom mapping and failed-write registers
// assumes a byte-addressed register port with one 32-bit word per offset
package unique_node_id_rom_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_ID_UPPER = 8'h24;
   localparam logic [7:0] OFS_ID_LOWER = 8'h28;
   localparam logic [7:0] OFS_MAP = 8'h34;
   localparam logic [7:0] OFS_FAIL_LOW = 8'h38;
   localparam logic [7:0] OFS_FAIL_HIGH = 8'h3C;
   localparam logic [7:0] OFS_IRQ_STATUS = 8'h60;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h64;
   localparam logic [7:0] OFS_LOCK_STATUS = 8'h68;
   localparam logic [7:0] OFS_FW_UPPER = 8'h70;
   localparam logic [7:0] OFS_FW_LOWER = 8'h74;
   // reset values
   localparam logic [31:0] ID_RESET = 32'h0000_0000;
   localparam logic [31:0] MAP_RESET = 32'h0000_0000;
   localparam logic [31:0] FAIL_RESET = 32'h0000_0000;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   // mapping register: base in bits 31..10, low bits read zero
   localparam int MAP_BASE_LSB = 10;
   localparam logic [31:0] MAP_KEEP = 32'hFFFF_FC00;
   // configuration rom window of the 48-bit 1394 offset
   localparam logic [47:0] ROM_WIN_LO = 48'hFFFF_F000_0400;
   localparam logic [47:0] ROM_WIN_HI = 48'hFFFF_F000_07FF;
   // failed-write high capture: requester id over offset bits 47..32
   localparam int SRC_LSB = 16;
   // interrupt status bits
   localparam int IRQ_W = 3;
   localparam int IRQ_FAIL_BIT = 0;
   localparam int IRQ_LOCK_BIT = 1;
   localparam int IRQ_REFUSE_BIT = 2;

   // true when a 1394 offset falls inside the rom mapping window
   function automatic logic in_rom_window(input logic [47:0] ofs);
      return (ofs >= ROM_WIN_LO) && (ofs <= ROM_WIN_HI);
   endfunction : in_rom_window
endpackage : unique_node_id_rom_pkg

// ---- logic/id_load_if.sv ----
// load path between the register bank and one unique-id word slot
// assumes both ends share the bank clock
`timescale 1ns/1ps
`default_nettype none
interface id_load_if;
   logic load_valid; // one-cycle load request
   logic [31:0] load_data; // word to load
   logic [31:0] value; // held word
   logic locked; // set once a load has landed
   modport ctrl (output load_valid, output load_data,
                 input value, input locked);
   modport slot (input load_valid, input load_data,
                 output value, output locked);
endinterface : id_load_if
`default_nettype wire

// ---- logic/unique_id_slot.sv ----
// one 32-bit word of the unique id with its load-once lock
// assumes reset_in is the global reset and nothing else clears it
`timescale 1ns/1ps
`default_nettype none
module unique_id_slot
   import unique_node_id_rom_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   id_load_if.slot load_port
);
   logic [31:0] value_reg; // the stored word
   logic locked_reg; // no more loads once high

   // first load wins; later attempts leave the word untouched
   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         value_reg <= ID_RESET;
         locked_reg <= 1'b0;
      end
      else if (load_port.load_valid && !locked_reg)
      begin
         value_reg <= load_port.load_data;
         locked_reg <= 1'b1;
      end
   end

   assign load_port.value = value_reg;
   assign load_port.locked = locked_reg;

   // once locked, the word and the lock never move again
   property p_slot_frozen;
      @(posedge clk_in) disable iff (reset_in)
      locked_reg |=> locked_reg && $stable(value_reg);
   endproperty
   a_slot_frozen: assert property (p_slot_frozen)
      else $error("locked id word changed");
endmodule : unique_id_slot
`default_nettype wire

// ---- tb/unique_node_id_rom_map_regs_tb_top.sv ----
// self-checking bench for the unique-id, rom mapping and capture bank
// assumes the bench owns every input; assertions live in the design files
`timescale 1ns/1ps
`default_nettype none
module unique_node_id_rom_map_regs_tb_top
   import unique_node_id_rom_pkg::*;
;
   logic clk = 1'h0; // 125 MHz bank clock
   logic reset = 1'h1; // global reset, held at start
   logic soft_reset = 1'h0; // software reset, must spare the id
   logic [7:0] addr = 8'h00; // register port
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic [31:0] rdata;
   logic ee_present = 1'h0; // eeprom side
   logic ee_valid = 1'h0;
   logic ee_lower = 1'h0;
   logic [31:0] ee_data = 32'h0000_0000;
   logic rom_valid = 1'h0; // received quadlet read
   logic [47:0] rom_ofs = 48'h0000_0000_0000;
   logic rom_av;
   logic [31:0] rom_addr;
   logic fail = 1'h0; // failed posted write
   logic [47:0] fail_ofs = 48'h0000_0000_0000;
   logic [15:0] fail_src = 16'h0000;
   logic [63:0] uid;
   logic irq;
   int failures = 0; // mismatches seen
   int checks = 0; // comparisons made

   // half period of 4 ns gives 8 ns
   always #4 clk = ~clk;

   unique_node_id_rom_map_regs #(.ADDR_W(8)) unique_node_id_rom_map_regs_inst (
      .clk_in(clk), .reset_in(reset), .soft_reset_in(soft_reset),
      .addr_in(addr), .wr_data_in(wdata), .wr_strobe_in(wr),
      .rd_strobe_in(rd), .rd_data_out(rdata),
      .eeprom_present_in(ee_present), .eeprom_load_valid_in(ee_valid),
      .eeprom_load_lower_in(ee_lower), .eeprom_load_data_in(ee_data),
      .rom_read_valid_in(rom_valid), .rom_read_offset_in(rom_ofs),
      .rom_host_addr_valid_out(rom_av), .rom_host_addr_out(rom_addr),
      .write_fail_in(fail), .write_fail_offset_in(fail_ofs),
      .write_fail_source_in(fail_src), .unique_id_out(uid),
      .irq_out(irq));

   // one compare for words; case equality so unknowns never match
   task automatic cmp_word(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : cmp_word

   // one compare for single flags
   task automatic cmp_bit(input string what, input logic exp,
                          input logic got);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %s expected %b seen %b", what, exp, got);
      end
   endtask : cmp_bit

   // global reset held for 8 cycles, released after an edge
   task automatic do_reset;
      @(posedge clk);
      reset <= 1'h1;
      repeat (8) @(posedge clk);
      reset <= 1'h0;
   endtask : do_reset

   // one-cycle write strobe
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask : bus_wr

   // read answer stands only in the cycle after the strobe
   task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      #1;
      cmp_word($sformatf("read %h", a), exp, rdata);
   endtask : bus_rd

   // the 64-bit id output lags the slots by a cycle, so settle first
   task automatic chk_uid(input logic [31:0] up, input logic [31:0] lo);
      repeat (2) @(posedge clk);
      #1;
      cmp_word("uid upper", up, uid[63:32]);
      cmp_word("uid lower", lo, uid[31:0]);
   endtask : chk_uid

   // eeprom word pulse
   task automatic ee_load(input logic lower, input logic [31:0] d);
      @(posedge clk);
      ee_valid <= 1'h1;
      ee_lower <= lower;
      ee_data <= d;
      @(posedge clk);
      ee_valid <= 1'h0;
   endtask : ee_load

   // quadlet read pulse; answer is judged in the cycle after it
   task automatic rom_rd(input logic [47:0] ofs, input logic hit,
                         input logic [31:0] exp);
      @(posedge clk);
      rom_valid <= 1'h1;
      rom_ofs <= ofs;
      @(posedge clk);
      rom_valid <= 1'h0;
      #1;
      cmp_bit("rom valid", hit, rom_av);
      cmp_word("rom addr", exp, rom_addr);
   endtask : rom_rd

   // failed posted write pulse
   task automatic fail_pulse(input logic [47:0] ofs, input logic [15:0] s);
      @(posedge clk);
      fail <= 1'h1;
      fail_ofs <= ofs;
      fail_src <= s;
      @(posedge clk);
      fail <= 1'h0;
   endtask : fail_pulse

   task automatic t_reset_values;
      bus_rd(OFS_ID_UPPER, ID_RESET);
      bus_rd(OFS_ID_LOWER, ID_RESET);
      bus_rd(OFS_MAP, MAP_RESET);
      chk_uid(32'h0000_0000, 32'h0000_0000);
      bus_rd(8'h10, 32'h0000_0000);
      $display("test reset_values done");
   endtask : t_reset_values

   // firmware loads once, later loads and register writes are refused
   task automatic t_fw_load;
      ee_load(1'h0, 32'h0BAD_F00D);
      bus_wr(OFS_FW_UPPER, 32'h1234_5678);
      bus_wr(OFS_FW_LOWER, 32'h9ABC_DEF0);
      bus_rd(OFS_LOCK_STATUS, 32'h0000_0003);
      bus_wr(OFS_FW_UPPER, 32'hFFFF_FFFF);
      bus_wr(OFS_FW_LOWER, 32'h0000_0001);
      bus_wr(OFS_ID_UPPER, 32'h5555_5555);
      bus_rd(OFS_ID_UPPER, 32'h1234_5678);
      bus_rd(OFS_ID_LOWER, 32'h9ABC_DEF0);
      chk_uid(32'h1234_5678, 32'h9ABC_DEF0);
      bus_rd(OFS_IRQ_STATUS, 32'h0000_0006);
      bus_wr(OFS_IRQ_STATUS, 32'h0000_0007);
      bus_rd(OFS_IRQ_STATUS, 32'h0000_0000);
      $display("test fw_load done");
   endtask : t_fw_load

   // a software reset must leave the id and its locks alone
   // a refused load raises an unmasked event first, so the clear shows
   task automatic t_soft_reset;
      bus_wr(OFS_IRQ_MASK, 32'h0000_0007);
      bus_wr(OFS_FW_UPPER, 32'h0000_0000);
      #1;
      cmp_bit("irq before soft reset", 1'h1, irq);
      @(posedge clk);
      soft_reset <= 1'h1;
      @(posedge clk);
      soft_reset <= 1'h0;
      bus_rd(OFS_ID_UPPER, 32'h1234_5678);
      bus_rd(OFS_ID_LOWER, 32'h9ABC_DEF0);
      bus_rd(OFS_LOCK_STATUS, 32'h0000_0003);
      bus_rd(OFS_IRQ_STATUS, 32'h0000_0000);
      bus_rd(OFS_IRQ_MASK, 32'h0000_0000);
      cmp_bit("irq after soft reset", 1'h0, irq);
      $display("test soft_reset done");
   endtask : t_soft_reset

   // window edges and just outside them; address holds on a miss
   task automatic t_map;
      bus_wr(OFS_MAP, 32'hFFFF_FFFF);
      bus_rd(OFS_MAP, 32'hFFFF_FC00);
      bus_wr(OFS_MAP, 32'h0001_2C00);
      rom_rd(48'hFFFF_F000_0404, 1'h1, 32'h0001_2C04);
      rom_rd(48'hFFFF_F000_0400, 1'h1, 32'h0001_2C00);
      rom_rd(48'hFFFF_F000_07FF, 1'h1, 32'h0001_2FFF);
      rom_rd(48'hFFFF_F000_0800, 1'h0, 32'h0001_2FFF);
      rom_rd(48'hFFFF_F000_03FF, 1'h0, 32'h0001_2FFF);
      $display("test map done");
   endtask : t_map

   // two failures with one idle cycle between: the later one wins; irq masked and cleared
   task automatic t_fail;
      bus_wr(OFS_IRQ_MASK, 32'h0000_0001);
      fail_pulse(48'h0101_0000_0001, 16'h0042);
      fail_pulse(48'hABCD_1234_5678, 16'h8F3A);
      repeat (2) @(posedge clk);
      #1;
      cmp_bit("irq set", 1'h1, irq);
      bus_wr(OFS_FAIL_LOW, 32'h0000_0000);
      bus_rd(OFS_FAIL_LOW, 32'h1234_5678);
      bus_rd(OFS_FAIL_HIGH, 32'h8F3A_ABCD);
      bus_wr(OFS_IRQ_STATUS, 32'h0000_0001);
      repeat (2) @(posedge clk);
      #1;
      cmp_bit("irq cleared", 1'h0, irq);
      bus_wr(OFS_IRQ_MASK, 32'h0000_0000);
      fail_pulse(48'h0000_FFFF_0000, 16'h0001);
      repeat (2) @(posedge clk);
      #1;
      cmp_bit("irq masked", 1'h0, irq);
      bus_rd(OFS_IRQ_STATUS, 32'h0000_0001);
      $display("test fail done");
   endtask : t_fail

   // global reset clears the id, then the eeprom loads it once
   task automatic t_eeprom;
      do_reset();
      bus_rd(OFS_ID_UPPER, ID_RESET);
      bus_rd(OFS_LOCK_STATUS, 32'h0000_0000);
      @(posedge clk);
      ee_present <= 1'h1;
      ee_load(1'h0, 32'h0A0B_0C0D);
      ee_load(1'h1, 32'h1122_3344);
      bus_wr(OFS_FW_UPPER, 32'h7777_7777);
      ee_load(1'h1, 32'h0000_0000);
      bus_rd(OFS_ID_UPPER, 32'h0A0B_0C0D);
      bus_rd(OFS_ID_LOWER, 32'h1122_3344);
      bus_rd(OFS_LOCK_STATUS, 32'h0000_0003);
      bus_rd(OFS_IRQ_STATUS, 32'h0000_0006);
      chk_uid(32'h0A0B_0C0D, 32'h1122_3344);
      $display("test eeprom done");
   endtask : t_eeprom

   // verdict: counts first, then exactly one closing message
   task automatic end_of_test;
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   // main sequence
   initial
   begin
      do_reset();
      t_reset_values();
      t_fw_load();
      t_soft_reset();
      t_map();
      t_fail();
      t_eeprom();
      end_of_test();
   end

   // the tests need about 140 cycles; far beyond that means a hang
   initial
   begin
      repeat (4000) @(posedge clk);
      failures++;
      end_of_test();
   end
endmodule : unique_node_id_rom_map_regs_tb_top
`default_nettype wire
